/* File: core/lrtr_pkg.sv */
package lrtr_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_SUPSTAT = 8'h02;
  localparam logic [7:0] ADDR_TEMP    = 8'h0E;
  localparam logic [7:0] ADDR_LOCK    = 8'h10;

  // Field positions in the lock register
  localparam int LOCK_BIT = 7;
  localparam int MASK_BIT = 3;
  localparam int KEY_HI   = 1;
  localparam int KEY_LO   = 0;

  // Reset values
  localparam logic [7:0] LOCK_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Key values {bit1, bit0} of the three restart writes
  localparam logic [1:0] KEY_STEP1 = 2'h0;
  localparam logic [1:0] KEY_STEP2 = 2'h3;
  localparam logic [1:0] KEY_STEP3 = 2'h2;
  localparam logic [1:0] KEY_READ  = 2'h0;

  // Supply recovery interval; least time, rounded up to cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam int RCV_TIME_NS   = 1000;
  localparam int RCV_CYCLES    =
    (RCV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Integrity code polynomial and seed
  localparam logic [7:0] CODE_POLY = 8'h2F;
  localparam logic [7:0] CODE_SEED = 8'hFF;

  // Restart key tracker, Gray coded along the path
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ONE  = 2'b01,
    KEY_TWO  = 2'b11
  } lrtr_key_t;

endpackage

/* File: core/lrtr_supply.sv */
`timescale 1ns/1ps
`default_nettype none
module lrtr_supply
  import lrtr_pkg::*;
#(
  parameter int RCV = RCV_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_supply_err,
  input  wire logic i_spi_mode,
  input  wire logic i_mask,
  input  wire logic i_status_rd,
  input  wire logic i_tx_err,
  input  wire logic i_resp_done,
  output logic      o_err,
  output logic      o_timer_zero,
  output logic      o_resp_inhibit,
  output logic      o_send_err_code
);
  localparam int CW = $clog2(RCV + 1);
  localparam logic [CW-1:0] RCV_LD = CW'(RCV);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          err_q, err_d;
  logic          code_q, code_d;
  logic          zero, expire, clr;

  assign zero = (cnt_q == '0);
  // Timer leaves one only toward zero when no error is present
  assign expire = (cnt_q == CW'(1)) && !i_supply_err;

  // Next timer, flag and error code request
  always_comb begin
    cnt_d = cnt_q;
    // R16: shared timer reload
    if (i_supply_err) begin
      cnt_d = RCV_LD;
    end else if (!zero) begin
      cnt_d = cnt_q - CW'(1);
    end
    // R7: clear only at zero
    if (i_spi_mode && !i_mask) begin
      clr = zero && (i_status_rd || i_tx_err);
    // R8: automatic clear at zero
    end else if (i_spi_mode) begin
      clr = zero;
    // R9: I2C clears on status read
    end else begin
      clr = zero && i_status_rd;
    end
    // Set wins so a fresh fault is never lost in a clear cycle
    err_d = i_supply_err || (err_q && !clr);
    // R6: error code for one response
    code_d = code_q;
    if (expire && i_spi_mode && !i_mask) begin
      code_d = 1'b1;
    end else if (i_resp_done) begin
      code_d = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= '0;
      err_q  <= 1'b0;
      code_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      err_q  <= err_d;
      code_q <= code_d;
    end
  end

  assign o_err           = err_q;
  assign o_timer_zero    = zero;
  // R9: silent while timer runs
  assign o_resp_inhibit  = !zero;
  assign o_send_err_code = code_q;

  chk_reload_timer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_supply_err |=> cnt_q == RCV_LD) // R16
    else $error("timer not reloaded on supply error");
  chk_auto_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_spi_mode && i_mask && zero && !i_supply_err |=> !err_q) // R8
    else $error("masked supply error not cleared at zero");
  chk_silent_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_supply_err |=> o_resp_inhibit [*2]) // R9
    else $error("response allowed while timer runs");
endmodule
`default_nettype wire

/* File: core/lrtr_integ.sv */
`timescale 1ns/1ps
`default_nettype none
module lrtr_integ
  import lrtr_pkg::*;
#(
  parameter int W = 34
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_enable,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_clr,
  output logic              o_err
);
  logic [7:0] ref_q, ref_d, code;
  logic       en_q, err_q, err_d, mismatch;

  // Bitwise code over the guarded image
  function automatic logic [7:0] calc_code(input logic [W-1:0] d);
    logic [7:0] c;
    c = CODE_SEED;
    for (int i = 0; i < W; i++) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CODE_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  assign code = calc_code(i_data);
  assign mismatch = en_q && (code != ref_q);

  // R4: reference taken at lock, then checked
  always_comb begin
    ref_d = ref_q;
    if (i_enable && !en_q) begin
      ref_d = code;
    end
    err_d = mismatch || (err_q && !i_clr);
  end

  // Reference and sticky flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_q <= DATA_RST;
      en_q  <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      en_q  <= i_enable;
      err_q <= err_d;
    end
  end

  assign o_err = err_q;

  chk_integ_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    en_q && (code != ref_q) |=> o_err) // R4
    else $error("integrity mismatch not flagged");
endmodule
`default_nettype wire

/* File: core/lrtr_top.sv */
// Contract
// R1: Read-only temperature register, zero after reset
// R2: Lock freezes writes except key bits
// R3: Lock bit clears only by reset
// R4: Locked state checks integrity code continuously
// R5: Lock disables and refuses self-test
// R6: SPI unmasked: silent, then one error code
// R7: SPI unmasked: clear on read/transmit at zero
// R8: SPI masked: silent while timer, auto clear
// R9: I2C: silent until expiry, clear on read
// R10: Keys 00,11,10 in order trigger reset
// R11: Reads show key zero, abort sequence
// R12: Write response echoes new value with keys
// R13: Third key write: no response, no ack
// R14: Key bits excluded from integrity code
// R15: Mask at bit 3, lock resets zero
// R16: Shared recovery timer reloads during errors
// R17: Broken order restarts tracking; 00 counts first
`timescale 1ns/1ps
`default_nettype none
module lrtr_top
  import lrtr_pkg::*;
#(
  parameter int USER_REGS = 4,
  parameter int RCV       = RCV_CYCLES
) (
  input  wire logic                   I_MCLK,
  input  wire logic                   I_RESETN,
  input  wire logic                   I_SPI_MODE,
  input  wire logic                   I_REG_WR,
  input  wire logic                   I_REG_RD,
  input  wire logic [7:0]             I_REG_ADDR,
  input  wire logic [7:0]             I_REG_WDATA,
  input  wire logic [7:0]             I_TEMP_VALUE,
  input  wire logic [USER_REGS*8-1:0] I_USER_REGS,
  input  wire logic                   I_INTEG_CLR,
  input  wire logic                   I_SUPPLY_ERR,
  input  wire logic                   I_TX_SUPPLY_ERR,
  input  wire logic                   I_RESP_DONE,
  input  wire logic                   I_SELFTEST_REQ,
  output logic [7:0]                  O_REG_RDATA,
  output logic                        O_RD_VALID,
  output logic [7:0]                  O_WR_ECHO,
  output logic                        O_WR_VALID,
  output logic                        O_WR_ENABLE,
  output logic                        O_NO_RESPONSE,
  output logic                        O_SEND_ERR_CODE,
  output logic                        O_SUPPLY_ERR,
  output logic                        O_INTEG_ERR,
  output logic                        O_SELFTEST_GO,
  output logic                        O_SELFTEST_REFUSED,
  output logic                        O_SOFT_RESET
);
  logic       lock_q, lock_d, mask_q, mask_d;
  logic [7:0] temp_q, temp_d;
  logic [7:0] rdata_q, rdata_d, echo_q, echo_d;
  logic       rvalid_q, rvalid_d, wvalid_q, wvalid_d;
  logic       srst_q, srst_d;
  lrtr_key_t  seq_q, seq_d;
  logic [1:0] key;
  logic       wr_lock, third_key, status_rd, sup_inhibit;

  assign wr_lock   = I_REG_WR && (I_REG_ADDR == ADDR_LOCK);
  assign key       = {I_REG_WDATA[KEY_HI], I_REG_WDATA[KEY_LO]};
  assign third_key = wr_lock && (seq_q == KEY_TWO) && (key == KEY_STEP3);
  assign status_rd = I_REG_RD && (I_REG_ADDR == ADDR_SUPSTAT);

  // Lock register image; reserved bits read as zero
  function automatic logic [7:0] lock_image(input logic l, input logic m,
                                            input logic [1:0] k);
    logic [7:0] v;
    v = LOCK_RST;
    v[LOCK_BIT] = l;
    v[MASK_BIT] = m;
    v[KEY_HI]   = k[1];
    v[KEY_LO]   = k[0];
    return v;
  endfunction

  // Next register state, key tracking and answers
  always_comb begin
    lock_d   = lock_q;
    mask_d   = mask_q;
    seq_d    = seq_q;
    echo_d   = echo_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    wvalid_d = 1'b0;
    srst_d   = 1'b0;
    // R1: temperature sampled every cycle
    temp_d   = I_TEMP_VALUE;
    if (wr_lock) begin
      // R2: frozen once locked
      if (!lock_q) begin
        // R3: lock only ever sets here
        lock_d = I_REG_WDATA[LOCK_BIT];
        // R15: mask control at bit 3
        mask_d = I_REG_WDATA[MASK_BIT];
      end
      // R10: ordered key tracking
      case (seq_q)
        KEY_IDLE: begin
          seq_d = (key == KEY_STEP1) ? KEY_ONE : KEY_IDLE;
        end
        KEY_ONE: begin
          if (key == KEY_STEP2) begin
            seq_d = KEY_TWO;
          end else begin
            // R17: restart on broken order
            seq_d = (key == KEY_STEP1) ? KEY_ONE : KEY_IDLE;
          end
        end
        KEY_TWO: begin
          if (key == KEY_STEP3) begin
            srst_d = 1'b1;
            seq_d  = KEY_IDLE;
          end else begin
            seq_d = (key == KEY_STEP1) ? KEY_ONE : KEY_IDLE;
          end
        end
        default: begin
          seq_d = KEY_IDLE;
        end
      endcase
      // R12: echo of new value and keys
      if (!third_key) begin
        wvalid_d = 1'b1;
        echo_d   = lock_image(lock_d, mask_d, key);
      end
    end else if (I_REG_WR) begin
      // Any other write breaks the consecutive run
      seq_d = KEY_IDLE;
    end
    // R11: read aborts, key field reads zero
    if (I_REG_RD) begin
      seq_d    = KEY_IDLE;
      rvalid_d = 1'b1;
      case (I_REG_ADDR)
        ADDR_TEMP: rdata_d = temp_q;
        ADDR_LOCK: rdata_d = lock_image(lock_q, mask_q, KEY_READ);
        default:   rdata_d = DATA_RST;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      lock_q   <= 1'b0;
      mask_q   <= 1'b0;
      temp_q   <= TEMP_RST;
      rdata_q  <= DATA_RST;
      echo_q   <= DATA_RST;
      rvalid_q <= 1'b0;
      wvalid_q <= 1'b0;
      srst_q   <= 1'b0;
      seq_q    <= KEY_IDLE;
    end else begin
      lock_q   <= lock_d;
      mask_q   <= mask_d;
      temp_q   <= temp_d;
      rdata_q  <= rdata_d;
      echo_q   <= echo_d;
      rvalid_q <= rvalid_d;
      wvalid_q <= wvalid_d;
      srst_q   <= srst_d;
      seq_q    <= seq_d;
    end
  end

  // Supply error reporting and response gating
  lrtr_supply #(
    .RCV (RCV)
  ) u_supply (
    .i_clk           (I_MCLK),
    .i_rst_n         (I_RESETN),
    .i_supply_err    (I_SUPPLY_ERR),
    .i_spi_mode      (I_SPI_MODE),
    .i_mask          (mask_q),
    .i_status_rd     (status_rd),
    .i_tx_err        (I_TX_SUPPLY_ERR),
    .i_resp_done     (I_RESP_DONE),
    .o_err           (O_SUPPLY_ERR),
    .o_timer_zero    (),
    .o_resp_inhibit  (sup_inhibit),
    .o_send_err_code (O_SEND_ERR_CODE)
  );

  // R14: guarded image leaves out key bits
  lrtr_integ #(
    .W (USER_REGS * 8 + 2)
  ) u_integ (
    .i_clk    (I_MCLK),
    .i_rst_n  (I_RESETN),
    .i_enable (lock_q),
    .i_data   ({I_USER_REGS, lock_q, mask_q}),
    .i_clr    (I_INTEG_CLR),
    .o_err    (O_INTEG_ERR)
  );

  // R2: other registers accept writes only before lock
  assign O_WR_ENABLE = !lock_q;
  // R13: third key write gets no response or ack
  assign O_NO_RESPONSE = third_key || sup_inhibit;
  // R5: self-test gated by lock
  assign O_SELFTEST_GO      = I_SELFTEST_REQ && !lock_q;
  assign O_SELFTEST_REFUSED = I_SELFTEST_REQ && lock_q;
  assign O_REG_RDATA  = rdata_q;
  assign O_RD_VALID   = rvalid_q;
  assign O_WR_ECHO    = echo_q;
  assign O_WR_VALID   = wvalid_q;
  assign O_SOFT_RESET = srst_q;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);

  chk_temp_read: assert property (
    I_REG_RD && I_REG_ADDR == ADDR_TEMP |=> O_REG_RDATA == $past(temp_q)) // R1
    else $error("temperature read returned wrong value");
  chk_lock_freeze: assert property (
    lock_q && wr_lock |=> mask_q == $past(mask_q)) // R2
    else $error("mask changed while locked");
  chk_lock_sticky: assert property (lock_q |=> lock_q) // R3
    else $error("lock bit cleared without reset");
  chk_selftest_block: assert property (
    lock_q |-> !O_SELFTEST_GO) // R5
    else $error("self-test started while locked");
  chk_key_sequence: assert property (
    wr_lock && seq_q == KEY_ONE && key == KEY_STEP2 && !I_REG_RD
    |=> seq_q == KEY_TWO && !O_SOFT_RESET) // R10
    else $error("second key step not tracked");
  chk_reset_cause: assert property (
    O_SOFT_RESET |-> $past(seq_q) == KEY_TWO) // R10
    else $error("reset without full key sequence");
  chk_read_abort: assert property (
    I_REG_RD |=> seq_q == KEY_IDLE && !O_SOFT_RESET) // R11
    else $error("read did not abort key sequence");
  chk_read_key_zero: assert property (
    I_REG_RD && I_REG_ADDR == ADDR_LOCK |=> O_REG_RDATA[1:0] == KEY_READ) // R11
    else $error("key field not zero on read");
  chk_echo_keys: assert property (
    wr_lock && !third_key |=> O_WR_VALID
    && O_WR_ECHO[1:0] == $past(key)) // R12
    else $error("write echo lacks new key bits");
  chk_third_silent: assert property (
    third_key |-> O_NO_RESPONSE ##1 !O_WR_VALID && O_SOFT_RESET) // R13
    else $error("third key write answered");
  chk_restart_first: assert property (
    wr_lock && key == KEY_STEP1 && !I_REG_RD |=> seq_q == KEY_ONE) // R17
    else $error("00 write did not restart tracking");

  cov_soft_reset: cover property (O_SOFT_RESET);
  cov_lock_set:   cover property (!lock_q ##1 lock_q);
  cov_err_code:   cover property (O_SEND_ERR_CODE ##1 !O_SEND_ERR_CODE);
  cov_integ_err:  cover property (lock_q && O_INTEG_ERR);
endmodule
`default_nettype wire

/* File: bench/lrtr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module lrtr_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_wr_echo,
  input  wire logic       i_wr_valid,
  input  wire logic       i_no_resp,
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  logic [7:0] got;    // Answer value of the last access
  logic       got_v;  // Answer strobe of the last access
  logic       got_nr; // Suppression seen while requesting

  // Idle bus: released lines show the inverse, never a stale copy
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // One access: strobe held across the taking edge, answer one cycle later
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge i_clk);
    o_wr    = wr;
    o_rd    = !wr;
    o_addr  = a;
    o_wdata = d;
    #1 got_nr = i_no_resp;
    @(negedge i_clk);
    got     = wr ? i_wr_echo : i_rdata;
    got_v   = wr ? i_wr_valid : i_rd_valid;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lrtr_pkg::*;
;
  localparam int RCV = 4;
  logic        mclk, resetn, spi, wr, rd, iclr, serr, txerr, rdone, streq;
  logic [7:0]  addr, wdata, temp, rdata, echo;
  logic [31:0] uregs;
  logic        rdv, wrv, wren, nr, sec, supe, inte, stgo, stref, srst;
  int          errors, n_compared, n;

  lrtr_top #(.USER_REGS(4), .RCV(RCV)) i_dut (
    .I_MCLK(mclk), .I_RESETN(resetn), .I_SPI_MODE(spi), .I_REG_WR(wr),
    .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_TEMP_VALUE(temp), .I_USER_REGS(uregs), .I_INTEG_CLR(iclr),
    .I_SUPPLY_ERR(serr), .I_TX_SUPPLY_ERR(txerr), .I_RESP_DONE(rdone),
    .I_SELFTEST_REQ(streq), .O_REG_RDATA(rdata), .O_RD_VALID(rdv),
    .O_WR_ECHO(echo), .O_WR_VALID(wrv), .O_WR_ENABLE(wren),
    .O_NO_RESPONSE(nr), .O_SEND_ERR_CODE(sec), .O_SUPPLY_ERR(supe),
    .O_INTEG_ERR(inte), .O_SELFTEST_GO(stgo), .O_SELFTEST_REFUSED(stref),
    .O_SOFT_RESET(srst));

  lrtr_host i_host (
    .i_clk(mclk), .i_rdata(rdata), .i_rd_valid(rdv), .i_wr_echo(echo),
    .i_wr_valid(wrv), .i_no_resp(nr), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));

  // Free running clock, 8 ns
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic check1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
  endtask

  task automatic lw(input logic [1:0] k);
    i_host.access(1'b1, ADDR_LOCK, {6'h00, k});
  endtask

  // Bounded wait for the response window to reopen
  task automatic wait_quiet();
    n = 0;
    while (nr !== 1'b0 && n < 50) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_regs();
    do_reset();
    temp = 8'h5A;
    cyc(2);
    i_host.access(1'b0, ADDR_TEMP, 8'h00);
    check8(i_host.got, 8'h5A);
    check1(i_host.got_v, 1'b1);
    i_host.access(1'b1, ADDR_TEMP, 8'hFF);
    i_host.access(1'b0, ADDR_TEMP, 8'h00);
    check8(i_host.got, 8'h5A);
    i_host.access(1'b0, ADDR_LOCK, 8'h00);
    check8(i_host.got, LOCK_RST);
    i_host.access(1'b1, ADDR_LOCK, 8'h0B);
    check8(i_host.got, 8'h0B);
    i_host.access(1'b0, ADDR_LOCK, 8'h00);
    check8(i_host.got, 8'h08);
    i_host.access(1'b0, 8'h55, 8'h00);
    check8(i_host.got, DATA_RST);
  endtask

  task automatic t_soft();
    do_reset();
    lw(KEY_STEP1);
    check8(i_host.got, 8'h00);
    lw(KEY_STEP2);
    check8(i_host.got, 8'h03);
    check1(srst, 1'b0);
    lw(KEY_STEP3);
    check1(i_host.got_v, 1'b0);
    check1(i_host.got_nr, 1'b1);
    check1(srst, 1'b1);
    // A read between steps drops the sequence
    lw(KEY_STEP1);
    i_host.access(1'b0, ADDR_LOCK, 8'h00);
    lw(KEY_STEP2);
    lw(KEY_STEP3);
    check1(srst, 1'b0);
    check1(i_host.got_v, 1'b1);
    // Foreign write between steps drops it as well
    lw(KEY_STEP1);
    i_host.access(1'b1, ADDR_TEMP, 8'h00);
    lw(KEY_STEP2);
    lw(KEY_STEP3);
    check1(srst, 1'b0);
    // Broken order, then a fresh first step
    lw(KEY_STEP1);
    lw(KEY_STEP2);
    lw(KEY_STEP1);
    lw(KEY_STEP2);
    lw(KEY_STEP3);
    check1(srst, 1'b1);
  endtask

  task automatic t_lock();
    do_reset();
    uregs = 32'h1234_5678;
    streq = 1'b1;
    #1 check1(stgo, 1'b1);
    cyc(1);
    streq = 1'b0;
    i_host.access(1'b1, ADDR_LOCK, 8'h88);
    check8(i_host.got, 8'h88);
    check1(wren, 1'b0);
    streq = 1'b1;
    #1 check1(stref, 1'b1);
    check1(stgo, 1'b0);
    cyc(1);
    streq = 1'b0;
    i_host.access(1'b1, ADDR_LOCK, 8'h00);
    check8(i_host.got, 8'h88);
    i_host.access(1'b1, ADDR_LOCK, 8'h03);
    check8(i_host.got, 8'h8B);
    cyc(3);
    check1(inte, 1'b0);
    i_host.access(1'b0, ADDR_LOCK, 8'h00);
    check8(i_host.got, 8'h88);
    uregs = 32'h1234_5679;
    cyc(3);
    check1(inte, 1'b1);
    uregs = 32'h1234_5678;
    cyc(2);
    iclr = 1'b1;
    cyc(1);
    iclr = 1'b0;
    cyc(2);
    check1(inte, 1'b0);
  endtask

  task automatic t_supply();
    do_reset();
    spi = 1'b1;
    serr = 1'b1;
    cyc(3);
    serr = 1'b0;
    check1(supe, 1'b1);
    check1(nr, 1'b1);
    // Transmission clear is refused while the timer runs
    txerr = 1'b1;
    cyc(1);
    txerr = 1'b0;
    check1(supe, 1'b1);
    wait_quiet();
    check1(n + 1 >= RCV - 1 && n + 1 <= RCV + 1, 1'b1);
    n = 0;
    while (sec !== 1'b1 && n < 3) begin
      cyc(1);
      n++;
    end
    check1(sec, 1'b1);
    rdone = 1'b1;
    cyc(1);
    rdone = 1'b0;
    cyc(1);
    check1(sec, 1'b0);
    txerr = 1'b1;
    cyc(1);
    txerr = 1'b0;
    cyc(1);
    check1(supe, 1'b0);
    // Masked: silent, then clears by itself
    i_host.access(1'b1, ADDR_LOCK, 8'h08);
    serr = 1'b1;
    cyc(1);
    serr = 1'b0;
    cyc(1);
    check1(nr, 1'b1);
    wait_quiet();
    cyc(2);
    check1(supe, 1'b0);
    check1(sec, 1'b0);
    // Two-wire mode keeps the flag until a status read
    spi = 1'b0;
    serr = 1'b1;
    cyc(1);
    serr = 1'b0;
    cyc(1);
    check1(nr, 1'b1);
    wait_quiet();
    cyc(2);
    check1(supe, 1'b1);
    i_host.access(1'b0, ADDR_SUPSTAT, 8'h00);
    cyc(1);
    check1(supe, 1'b0);
  endtask

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    errors++;
    final_report();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    resetn = 1'b0;
    spi = 1'b1;
    temp = 8'h00;
    uregs = 32'h0000_0000;
    iclr = 1'b0;
    serr = 1'b0;
    txerr = 1'b0;
    rdone = 1'b0;
    streq = 1'b0;
    t_regs();
    t_soft();
    t_lock();
    t_supply();
    final_report();
  end
endmodule
`default_nettype wire
